// file: rtc_consts.svh
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
// Register indices on the serial link; the bus byte address is four times the index.
`define RTC_IDX_SEC 4'h0
`define RTC_IDX_MIN 4'h1
`define RTC_IDX_HOUR 4'h2
`define RTC_IDX_WDAY 4'h3
`define RTC_IDX_DAY 4'h4
`define RTC_IDX_MON 4'h5
`define RTC_IDX_YEAR 4'h6
`define RTC_IDX_TRIM 4'h7
`define RTC_IDX_AW_MIN 4'h8
`define RTC_IDX_AW_HOUR 4'h9
`define RTC_IDX_AW_DAYS 4'hA
`define RTC_IDX_AD_MIN 4'hB
`define RTC_IDX_AD_HOUR 4'hC
`define RTC_IDX_CTRL1 4'hE
`define RTC_IDX_CTRL2 4'hF
// Control register 1 fields.
`define RTC_C1_WALE 7
`define RTC_C1_DALE 6
`define RTC_C1_H24 5
`define RTC_C1_SUBCLK_DIS2 4
`define RTC_C1_PER_LSB 0
// Control register 2 fields.
`define RTC_C2_VSEL 7
`define RTC_C2_VDROP 6
`define RTC_C2_OSC_STOP_FLAG 4
`define RTC_C2_SUBCLK_DIS1 3
`define RTC_C2_PERF 2
`define RTC_C2_WAF 1
`define RTC_C2_DAF 0
// Other field positions.
`define RTC_MON_CENTURY 7
`define RTC_HOUR_PM 5
`define RTC_TRIM_SIGN 6
// Reset image (register F in the top byte) and writable-bit masks.
`define RTC_RST_IMAGE 128'h1000_0000_0000_0000_0000_0101_0000_0000
`define RTC_WR_MASKS 128'hFFFF_003F_7F7F_3F7F_7FFF_9F3F_073F_7F7F
// Periodic interrupt selections.
`define RTC_PER_2HZ 3'h2
`define RTC_PER_1HZ 3'h3
`define RTC_PER_SEC 3'h4
`define RTC_PER_MIN 3'h5
`define RTC_PER_HOUR 3'h6
`define RTC_PER_MONTH 3'h7
// Oscillator timing.
`define RTC_OSC_PER_SEC 16'h8000
`define RTC_TRIM_STEP_CNT 2
`define RTC_CLK_MHZ 10
`define RTC_OSC_STOP_US 200
`define RTC_OSC_STOP_CYC (`RTC_OSC_STOP_US * `RTC_CLK_MHZ)
// Bus answers.
`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2
`endif

// file: rtc_pkg.sv
package rtc_pkg;
	typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_WRITE, SER_READ} ser_state_t;
	// The three link pins as seen from the device.
	typedef struct packed {
		logic select;
		logic shift_clk;
		logic data_in;
	} link_in_t;
	// Decoded serial command byte.
	typedef struct packed {
		logic [3:0] addr;
		logic rd;
	} ser_cmd_t;
endpackage : rtc_pkg

// file: serial_rtc_alarm_timer.sv
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rtc_consts.svh"
module serial_rtc_alarm_timer #(
	parameter int OSC_STOP_CYC = `RTC_OSC_STOP_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire rtc_pkg::link_in_t link_in,
	output logic serial_data_line_o,
	output logic serial_data_line_oe,
	output logic interrupt_request_out_o,
	output logic interrupt_request_out_oe,
	input wire logic osc_clock_in,
	input wire logic subclock_gate_input,
	output logic subclock_output,
	input wire logic supply_below_high,
	input wire logic supply_below_low
);
	logic [7:0] regs_ff [16];
	logic [7:0] nxt_regs [16];
	logic [2:0] sel_sync_ff, sclk_sync_ff, osc_sync_ff;
	logic [1:0] sio_sync_ff, gate_sync_ff, vhi_sync_ff, vlo_sync_ff;
	logic sclk_rise, sclk_fall, osc_rise;
	logic [15:0] sub_cnt_ff;
	logic [15:0] sec_period;
	logic sec_tick, min_tick, hour_tick, month_tick;
	logic [31:0] stop_cnt_ff;
	logic osc_stopped;
	logic [7:0] n_sec, n_min, n_hour, n_wday, n_day, n_mon, n_year;
	rtc_pkg::ser_state_t ser_state_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] in_sh_ff, out_sh_ff;
	logic [3:0] ser_addr_ff;
	logic ser_we_ff;
	logic [7:0] ser_wdata_ff;
	logic aw_got_ff, w_got_ff;
	logic [7:0] aw_addr_ff;
	logic [7:0] w_data_ff;
	logic w_lane0_ff;
	logic axi_we;
	logic [2:0] per_sel;
	logic pulse_level;
	logic interrupt_request_out_req;

	// BCD increment of a two-digit value.
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		return {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	// Leap test on a BCD year: even tens need ones 0/4/8, odd tens need 2/6.
	function automatic logic is_leap(input logic [7:0] y);
		if (y[4])
			return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
	endfunction : is_leap

	// Last day of a month in BCD.
	function automatic logic [7:0] last_day(input logic [4:0] m, input logic [7:0] y);
		if (m == 5'h02)
			return is_leap(y) ? 8'h29 : 8'h28;
		if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
			return 8'h30;
		return 8'h31;
	endfunction : last_day

	// Every pin crosses two flip-flops before any logic looks at it.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel_sync_ff <= 3'h0;
			sclk_sync_ff <= 3'h0;
			osc_sync_ff <= 3'h0;
			sio_sync_ff <= 2'h0;
			gate_sync_ff <= 2'h0;
			vhi_sync_ff <= 2'h0;
			vlo_sync_ff <= 2'h0;
		end
		else
		begin
			sel_sync_ff <= {sel_sync_ff[1:0], link_in.select};
			sclk_sync_ff <= {sclk_sync_ff[1:0], link_in.shift_clk};
			osc_sync_ff <= {osc_sync_ff[1:0], osc_clock_in};
			sio_sync_ff <= {sio_sync_ff[0], link_in.data_in};
			gate_sync_ff <= {gate_sync_ff[0], subclock_gate_input};
			vhi_sync_ff <= {vhi_sync_ff[0], supply_below_high};
			vlo_sync_ff <= {vlo_sync_ff[0], supply_below_low};
		end
	end

	assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
	assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
	assign osc_rise = osc_sync_ff[1] & ~osc_sync_ff[2];

	// Trim acts on seconds 00, 20 and 40 only, so one step is a few ppm of a twenty-second span.
	always_comb
	begin
		sec_period = `RTC_OSC_PER_SEC;
		if (regs_ff[`RTC_IDX_SEC] == 8'h00 || regs_ff[`RTC_IDX_SEC] == 8'h20 || regs_ff[`RTC_IDX_SEC] == 8'h40)
		begin
			if (regs_ff[`RTC_IDX_TRIM][`RTC_TRIM_SIGN])
				sec_period = `RTC_OSC_PER_SEC + 16'({regs_ff[`RTC_IDX_TRIM][5:0], 1'b0});
			else
				sec_period = `RTC_OSC_PER_SEC - 16'({regs_ff[`RTC_IDX_TRIM][5:0], 1'b0});
		end
	end

	assign sec_tick = osc_rise && (sub_cnt_ff >= sec_period - 16'h0001);

	// Oscillator edge divider for the second tick.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sub_cnt_ff <= 16'h0000;
		else if (sec_tick)
			sub_cnt_ff <= 16'h0000;
		else if (osc_rise)
			sub_cnt_ff <= sub_cnt_ff + 16'h0001;
	end

	// A long gap between oscillator edges counts as an oscillator stop.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || osc_rise)
			stop_cnt_ff <= 32'h0;
		else if (!osc_stopped)
			stop_cnt_ff <= stop_cnt_ff + 32'h1;
	end

	assign osc_stopped = (stop_cnt_ff >= 32'(OSC_STOP_CYC));

	// Calendar carry chain, all in packed BCD.
	always_comb
	begin
		logic [7:0] inc_v;
		inc_v = 8'h00;
		n_sec = bcd_inc(regs_ff[`RTC_IDX_SEC]);
		n_min = regs_ff[`RTC_IDX_MIN];
		n_hour = regs_ff[`RTC_IDX_HOUR];
		n_wday = regs_ff[`RTC_IDX_WDAY];
		n_day = regs_ff[`RTC_IDX_DAY];
		n_mon = regs_ff[`RTC_IDX_MON];
		n_year = regs_ff[`RTC_IDX_YEAR];
		min_tick = 1'b0;
		hour_tick = 1'b0;
		month_tick = 1'b0;
		if (regs_ff[`RTC_IDX_SEC] >= 8'h59)
		begin
			n_sec = 8'h00;
			min_tick = 1'b1;
			n_min = bcd_inc(regs_ff[`RTC_IDX_MIN]);
			if (regs_ff[`RTC_IDX_MIN] >= 8'h59)
			begin
				n_min = 8'h00;
				hour_tick = 1'b1;
				if (regs_ff[`RTC_IDX_CTRL1][`RTC_C1_H24])
					n_hour = (regs_ff[`RTC_IDX_HOUR] >= 8'h23) ? 8'h00 : bcd_inc(regs_ff[`RTC_IDX_HOUR]);
				else if (regs_ff[`RTC_IDX_HOUR][4:0] == 5'h11)
					n_hour = {2'b00, ~regs_ff[`RTC_IDX_HOUR][5], 5'h12};
				else if (regs_ff[`RTC_IDX_HOUR][4:0] == 5'h12)
					n_hour = {2'b00, regs_ff[`RTC_IDX_HOUR][5], 5'h01};
				else
				begin
					inc_v = bcd_inc({3'h0, regs_ff[`RTC_IDX_HOUR][4:0]});
					n_hour = {2'b00, regs_ff[`RTC_IDX_HOUR][5], inc_v[4:0]};
				end
				// The day ends at 23 in 24-hour mode and at PM 11 in 12-hour mode.
				if (regs_ff[`RTC_IDX_CTRL1][`RTC_C1_H24] ? (regs_ff[`RTC_IDX_HOUR] >= 8'h23)
					: (regs_ff[`RTC_IDX_HOUR] == 8'h31))
				begin
					n_wday = (regs_ff[`RTC_IDX_WDAY] >= 8'h06) ? 8'h00 : regs_ff[`RTC_IDX_WDAY] + 8'h01;
					n_day = bcd_inc(regs_ff[`RTC_IDX_DAY]);
					if (regs_ff[`RTC_IDX_DAY] >= last_day(regs_ff[`RTC_IDX_MON][4:0], regs_ff[`RTC_IDX_YEAR]))
					begin
						n_day = 8'h01;
						month_tick = 1'b1;
						inc_v = bcd_inc({3'h0, regs_ff[`RTC_IDX_MON][4:0]});
						n_mon = {regs_ff[`RTC_IDX_MON][7], 2'b00, inc_v[4:0]};
						if (regs_ff[`RTC_IDX_MON][4:0] >= 5'h12)
						begin
							n_mon = {regs_ff[`RTC_IDX_MON][7], 7'h01};
							n_year = bcd_inc(regs_ff[`RTC_IDX_YEAR]);
							if (regs_ff[`RTC_IDX_YEAR] >= 8'h99)
							begin
								n_year = 8'h00;
								n_mon[`RTC_MON_CENTURY] = ~regs_ff[`RTC_IDX_MON][`RTC_MON_CENTURY];
							end
						end
					end
				end
			end
		end
	end

	assign per_sel = regs_ff[`RTC_IDX_CTRL1][`RTC_C1_PER_LSB +: 3];
	// Pulse waveform: active for the first half of each period.
	assign pulse_level = (per_sel == `RTC_PER_2HZ) ? ~sub_cnt_ff[13] : ~sub_cnt_ff[14];

	// Next register image: time advance, then writes, then hardware flag sets, then stop clearing.
	always_comb
	begin
		logic [7:0] wmask;
		logic [7:0] wval;
		logic [3:0] widx;
		logic wen;
		wmask = 8'h00;
		wval = 8'h00;
		widx = 4'h0;
		wen = ser_we_ff | axi_we;
		for (int i = 0; i < 16; i++)
			nxt_regs[i] = regs_ff[i];
		if (sec_tick)
		begin
			nxt_regs[`RTC_IDX_SEC] = n_sec;
			nxt_regs[`RTC_IDX_MIN] = n_min;
			nxt_regs[`RTC_IDX_HOUR] = n_hour;
			nxt_regs[`RTC_IDX_WDAY] = n_wday;
			nxt_regs[`RTC_IDX_DAY] = n_day;
			nxt_regs[`RTC_IDX_MON] = n_mon;
			nxt_regs[`RTC_IDX_YEAR] = n_year;
		end
		if (wen)
		begin
			widx = ser_we_ff ? ser_addr_ff : aw_addr_ff[5:2];
			wval = ser_we_ff ? ser_wdata_ff : w_data_ff;
			wmask = 8'(`RTC_WR_MASKS >> {widx, 3'b000});
			nxt_regs[widx] = wval & wmask;
		end
		// Minute alarms are judged on the tick that carries the time into a new minute.
		if (sec_tick && min_tick)
		begin
			if (regs_ff[`RTC_IDX_CTRL1][`RTC_C1_WALE] && n_min == regs_ff[`RTC_IDX_AW_MIN]
				&& n_hour == regs_ff[`RTC_IDX_AW_HOUR] && regs_ff[`RTC_IDX_AW_DAYS][n_wday[2:0]])
				nxt_regs[`RTC_IDX_CTRL2][`RTC_C2_WAF] = 1'b1;
			if (regs_ff[`RTC_IDX_CTRL1][`RTC_C1_DALE] && n_min == regs_ff[`RTC_IDX_AD_MIN]
				&& n_hour == regs_ff[`RTC_IDX_AD_HOUR])
				nxt_regs[`RTC_IDX_CTRL2][`RTC_C2_DAF] = 1'b1;
		end
		// Level-style periodic selections follow the pulse waveform; event selections set a flag that is sticky until software writes a zero.
		if (per_sel == `RTC_PER_2HZ || per_sel == `RTC_PER_1HZ)
			nxt_regs[`RTC_IDX_CTRL2][`RTC_C2_PERF] = pulse_level;
		else if (sec_tick && ((per_sel == `RTC_PER_SEC) || (per_sel == `RTC_PER_MIN && min_tick)
			|| (per_sel == `RTC_PER_HOUR && hour_tick) || (per_sel == `RTC_PER_MONTH && month_tick)))
			nxt_regs[`RTC_IDX_CTRL2][`RTC_C2_PERF] = 1'b1;
		if (regs_ff[`RTC_IDX_CTRL2][`RTC_C2_VSEL] ? vlo_sync_ff[1] : vhi_sync_ff[1])
			nxt_regs[`RTC_IDX_CTRL2][`RTC_C2_VDROP] = 1'b1;
		if (osc_stopped)
			nxt_regs[`RTC_IDX_CTRL2][`RTC_C2_OSC_STOP_FLAG] = 1'b1;
		// While the stop flag stands, trim and control register 1 are held at zero and control register 2 keeps only the stop flag.
		if (nxt_regs[`RTC_IDX_CTRL2][`RTC_C2_OSC_STOP_FLAG])
		begin
			nxt_regs[`RTC_IDX_TRIM] = 8'h00;
			nxt_regs[`RTC_IDX_CTRL1] = 8'h00;
			nxt_regs[`RTC_IDX_CTRL2] = 8'h00;
			nxt_regs[`RTC_IDX_CTRL2][`RTC_C2_OSC_STOP_FLAG] = 1'b1;
		end
	end

	// Register file; power-on image has the stop flag set.
	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < 16; i++)
			regs_ff[i] <= aresetn ? nxt_regs[i] : 8'(`RTC_RST_IMAGE >> (i * 8));
	end

	// Serial engine: command byte is address in the upper nibble and a read flag in bit 3.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !sel_sync_ff[1])
		begin
			ser_state_ff <= rtc_pkg::SER_IDLE;
			bit_cnt_ff <= 3'h0;
			in_sh_ff <= 8'h00;
			out_sh_ff <= 8'h00;
			ser_addr_ff <= 4'h0;
			ser_we_ff <= 1'b0;
			ser_wdata_ff <= 8'h00;
			serial_data_line_o <= 1'b0;
			serial_data_line_oe <= 1'b0;
		end
		else
		begin
			ser_we_ff <= 1'b0;
			case (ser_state_ff)
				rtc_pkg::SER_IDLE:
				begin
					ser_state_ff <= rtc_pkg::SER_CMD;
					bit_cnt_ff <= 3'h0;
				end
				rtc_pkg::SER_CMD:
				begin
					if (sclk_rise)
					begin
						in_sh_ff <= {in_sh_ff[6:0], sio_sync_ff[1]};
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h7)
						begin
							ser_addr_ff <= in_sh_ff[6:3];
							ser_state_ff <= in_sh_ff[2] ? rtc_pkg::SER_READ : rtc_pkg::SER_WRITE;
						end
					end
				end
				rtc_pkg::SER_WRITE:
				begin
					if (sclk_rise)
					begin
						in_sh_ff <= {in_sh_ff[6:0], sio_sync_ff[1]};
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h7)
						begin
							ser_wdata_ff <= {in_sh_ff[6:0], sio_sync_ff[1]};
							ser_we_ff <= 1'b1;
						end
					end
					// Burst writes step to the next address after each byte.
					if (ser_we_ff)
						ser_addr_ff <= ser_addr_ff + 4'h1;
				end
				rtc_pkg::SER_READ:
				begin
					if (sclk_fall)
					begin
						serial_data_line_oe <= 1'b1;
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h0)
						begin
							serial_data_line_o <= regs_ff[ser_addr_ff][7];
							out_sh_ff <= {regs_ff[ser_addr_ff][6:0], 1'b0};
						end
						else
						begin
							serial_data_line_o <= out_sh_ff[7];
							out_sh_ff <= {out_sh_ff[6:0], 1'b0};
						end
						if (bit_cnt_ff == 3'h7)
							ser_addr_ff <= ser_addr_ff + 4'h1;
					end
				end
				default:
					ser_state_ff <= rtc_pkg::SER_IDLE;
			endcase
		end
	end

	// Bus write: address and data are taken in either order; a serial write in the same cycle goes first.
	assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
	assign axi_we = aw_got_ff && w_got_ff && !s_axi_bvalid && !ser_we_ff && w_lane0_ff
		&& (aw_addr_ff[7:6] == 2'b00);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 8'h00;
			w_lane0_ff <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RTC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_ff <= 1'b1;
				w_data_ff <= s_axi_wdata[7:0];
				w_lane0_ff <= s_axi_wstrb[0];
			end
			if (aw_got_ff && w_got_ff && !s_axi_bvalid && !ser_we_ff)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_ff[7:6] == 2'b00) ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Bus read: one cycle to the answer; reads have no side effects.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RTC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= (s_axi_araddr[7:6] == 2'b00) ? {24'h00_0000, regs_ff[s_axi_araddr[5:2]]} : 32'h0000_0000;
			s_axi_rresp <= (s_axi_araddr[7:6] == 2'b00) ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Shared open-drain interrupt: pulls low while any enabled source stands.
	assign interrupt_request_out_req = (regs_ff[`RTC_IDX_CTRL1][`RTC_C1_WALE] && regs_ff[`RTC_IDX_CTRL2][`RTC_C2_WAF])
		|| (regs_ff[`RTC_IDX_CTRL1][`RTC_C1_DALE] && regs_ff[`RTC_IDX_CTRL2][`RTC_C2_DAF])
		|| (per_sel >= `RTC_PER_2HZ && regs_ff[`RTC_IDX_CTRL2][`RTC_C2_PERF]);

	// Subclock is cut when the gate input is low or when both disable bits are set, so one stray write cannot stop it.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			interrupt_request_out_o <= 1'b0;
			interrupt_request_out_oe <= 1'b0;
			subclock_output <= 1'b0;
		end
		else
		begin
			interrupt_request_out_o <= 1'b0;
			interrupt_request_out_oe <= interrupt_request_out_req;
			subclock_output <= osc_sync_ff[1] && gate_sync_ff[1]
				&& !(regs_ff[`RTC_IDX_CTRL1][`RTC_C1_SUBCLK_DIS2] && regs_ff[`RTC_IDX_CTRL2][`RTC_C2_SUBCLK_DIS1]);
		end
	end
endmodule : serial_rtc_alarm_timer

// file: serial_rtc_alarm_timer_assertions.sv
`timescale 1ns/1ps
`include "rtc_consts.svh"
// Pin inputs are asynchronous, so the pin checks allow for the two-stage synchroniser and one register.
module rtc_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire rtc_pkg::link_in_t link_in,
	input wire logic serial_data_line_oe,
	input wire logic interrupt_request_out_o,
	input wire logic subclock_gate_input,
	input wire logic subclock_output
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic aw_bad_ff;
	logic ar_bad_ff;
	// Remember whether the write address in flight lies outside the map.
	always_ff @(posedge aclk)
		if (!aresetn)
			aw_bad_ff <= 1'h0;
		else if (s_axi_awvalid && s_axi_awready)
			aw_bad_ff <= |s_axi_awaddr[7:6];
	// Same for the read address.
	always_ff @(posedge aclk)
		if (!aresetn)
			ar_bad_ff <= 1'h0;
		else if (s_axi_arvalid && s_axi_arready)
			ar_bad_ff <= |s_axi_araddr[7:6];
	bresp_code_a: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (aw_bad_ff ? `RTC_RESP_SLVERR : 2'h0))
		else $error("write response code wrong for address");
	rresp_code_a: assert property ($rose(s_axi_rvalid) |->
		s_axi_rresp == (ar_bad_ff ? `RTC_RESP_SLVERR : 2'h0) && (!ar_bad_ff || s_axi_rdata == 32'h0))
		else $error("read response wrong for address");
	rdata_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data above the register byte not zero");
	read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	data_release_a: assert property (!link_in.select [*5] |-> !serial_data_line_oe)
		else $error("data line driven while not selected");
	drive_selected_a: assert property ($rose(serial_data_line_oe) |-> link_in.select)
		else $error("data line driven outside a frame");
	interrupt_request_out_drain_a: assert property (interrupt_request_out_o == 1'h0)
		else $error("interrupt pin driven high");
	subclk_gate_a: assert property (!subclock_gate_input [*5] |-> !subclock_output)
		else $error("subclock running with gate low");
endmodule : rtc_checker

bind serial_rtc_alarm_timer rtc_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_in, .serial_data_line_oe,
	.interrupt_request_out_o, .subclock_gate_input, .subclock_output);

// file: rtc_host_link.sv
`timescale 1ns/1ps
// Host end of the three-wire link; the shift clock stands still between frames.
module rtc_host_link (
	input wire logic sdl_o,
	input wire logic sdl_oe,
	output rtc_pkg::link_in_t link_in
);
	localparam realtime HALF_NS = 400.0;
	logic sel = 1'h0;
	logic sck = 1'h0;
	logic hbit = 1'h0;
	logic hdrive = 1'h0;
	// An undriven wire shows the inverse of the last level, so a stale bit can never pass for data.
	assign link_in = '{select: sel, shift_clk: sck, data_in: sdl_oe ? sdl_o : (hdrive ? hbit : !hbit)};
	// One frame: command byte then one data byte, MSB first; en low clocks with select held low.
	task automatic xfer(input logic en, input logic [3:0] a, input logic rd, input logic [7:0] wd,
		output logic [7:0] rdat);
		logic [15:0] bits;
		bits = {a, rd, 3'h5, wd};
		rdat = 8'h00;
		#37;
		sel = en;
		hdrive = 1'h1;
		#(HALF_NS);
		for (int i = 15; i >= 0; i--)
		begin
			if (rd && i == 7)
				hdrive = 1'h0;
			hbit = bits[i];
			#(HALF_NS);
			sck = 1'h1;
			#50;
			if (i < 8)
				rdat[i] = link_in.data_in;
			#(HALF_NS - 50.0);
			sck = 1'h0;
		end
		#(HALF_NS);
		sel = 1'h0;
		hdrive = 1'h0;
		#(HALF_NS * 4.0);
	endtask : xfer
endmodule : rtc_host_link

// file: serial_rtc_alarm_timer_tb.sv
`timescale 1ns/1ps
`include "rtc_consts.svh"
module serial_rtc_alarm_timer_tb;
	localparam int STOP_CYC = 1000;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic osc_clock_in = 1'h0, osc_run = 1'h1, subclock_gate_input = 1'h1;
	logic supply_below_high = 1'h0, supply_below_low = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, subclock_output;
	logic serial_data_line_o, serial_data_line_oe, interrupt_request_out_o, interrupt_request_out_oe;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] rd_byte;
	rtc_pkg::link_in_t link_in;
	int n_mismatch = 0;
	int n_tests = 0;

	serial_rtc_alarm_timer #(.OSC_STOP_CYC(STOP_CYC)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .link_in, .serial_data_line_o, .serial_data_line_oe, .interrupt_request_out_o,
		.interrupt_request_out_oe, .osc_clock_in, .subclock_gate_input, .subclock_output, .supply_below_high,
		.supply_below_low);
	rtc_host_link u_host (.sdl_o(serial_data_line_o), .sdl_oe(serial_data_line_oe), .link_in(link_in));

	// Bus clock, 100 ns period.
	initial
		forever #50 aclk = ~aclk;
	// Oscillator at half the bus clock, so one whole second of time fits in the run.
	always @(posedge aclk)
		if (osc_run)
			osc_clock_in <= ~osc_clock_in;

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Write and read cycles; ready is raised only once the answer shows, so the slave's hold is exercised.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] strb, input logic [1:0] er);
		logic done;
		done = 1'h0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'h1;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= strb;
		s_axi_wvalid <= 1'h1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bready && s_axi_bvalid)
			begin
				chk({30'h0, s_axi_bresp}, {30'h0, er});
				s_axi_bready <= 1'h0;
				done = 1'h1;
			end
			else if (s_axi_bvalid)
				s_axi_bready <= 1'h1;
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
		logic done;
		done = 1'h0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rready && s_axi_rvalid)
			begin
				chk(s_axi_rdata, {24'h0, exp});
				chk({30'h0, s_axi_rresp}, {30'h0, er});
				s_axi_rready <= 1'h0;
				done = 1'h1;
			end
			else if (s_axi_rvalid)
				s_axi_rready <= 1'h1;
		end
	endtask : rd

	task automatic wi(input logic [3:0] idx, input logic [7:0] d);
		wr({2'h0, idx, 2'h0}, d, 4'hF, `RTC_RESP_OKAY);
	endtask : wi

	task automatic ri(input logic [3:0] idx, input logic [7:0] exp);
		rd({2'h0, idx, 2'h0}, exp, `RTC_RESP_OKAY);
	endtask : ri

	// Link frame, then realign to the bus clock before the next bus cycle.
	task automatic link(input logic en, input logic [3:0] a, input logic r, input logic [7:0] d);
		u_host.xfer(en, a, r, d, rd_byte);
		@(posedge aclk);
	endtask : link

	// Counts subclock edges over 1000 cycles after letting the synchronisers settle.
	task automatic sub_chk(input logic run);
		int n;
		logic last;
		n = 0;
		repeat (4) @(posedge aclk);
		last = subclock_output;
		repeat (1000)
		begin
			@(posedge aclk);
			if (subclock_output !== last)
				n++;
			last = subclock_output;
		end
		chk({31'h0, n > 0}, {31'h0, run});
	endtask : sub_chk

	task automatic droop(input logic hi, input logic lo);
		supply_below_high <= hi;
		supply_below_low <= lo;
		repeat (10) @(posedge aclk);
		supply_below_high <= 1'h0;
		supply_below_low <= 1'h0;
		@(posedge aclk);
	endtask : droop

	// A clean run waits about 67000 cycles for its one second tick; 90000 means a hang.
	initial
	begin
		#(90000 * 100);
		n_mismatch++;
		summarize();
	end

	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		ri(`RTC_IDX_CTRL2, 8'h10);
		ri(`RTC_IDX_DAY, 8'h01);
		ri(`RTC_IDX_MON, 8'h01);
		ri(`RTC_IDX_CTRL1, 8'h00);
		sub_chk(1'h1);
		$display("reset values done");
		wi(`RTC_IDX_CTRL1, 8'h20);
		wi(`RTC_IDX_TRIM, 8'h15);
		ri(`RTC_IDX_CTRL1, 8'h00);
		ri(`RTC_IDX_TRIM, 8'h00);
		wi(`RTC_IDX_CTRL2, 8'h00);
		ri(`RTC_IDX_CTRL2, 8'h00);
		wi(`RTC_IDX_CTRL1, 8'h20);
		wi(`RTC_IDX_TRIM, 8'hFF);
		ri(`RTC_IDX_TRIM, 8'h7F);
		$display("stop flag forcing done");
		for (int i = 0; i < 14; i++)
		begin
			wi(i[3:0], 8'hFF);
			ri(i[3:0], 8'(`RTC_WR_MASKS >> (8 * i)));
		end
		wr(8'h40, 8'h55, 4'hF, `RTC_RESP_SLVERR);
		rd(8'hFC, 8'h00, `RTC_RESP_SLVERR);
		wr({2'h0, `RTC_IDX_MIN, 2'h0}, 8'h00, 4'hE, `RTC_RESP_OKAY);
		ri(`RTC_IDX_MIN, 8'h7F);
		$display("register map done");
		wi(`RTC_IDX_CTRL1, 8'h22);
		ri(`RTC_IDX_CTRL2, 8'h04);
		chk({31'h0, interrupt_request_out_oe}, 32'h1);
		wi(`RTC_IDX_CTRL1, 8'h20);
		chk({31'h0, interrupt_request_out_oe}, 32'h0);
		wi(`RTC_IDX_CTRL2, 8'h00);
		$display("periodic pulse done");
		link(1'h1, `RTC_IDX_MIN, 1'h0, 8'h45);
		ri(`RTC_IDX_MIN, 8'h45);
		link(1'h1, `RTC_IDX_MIN, 1'h1, 8'h00);
		chk({24'h0, rd_byte}, 32'h45);
		link(1'h0, `RTC_IDX_MIN, 1'h0, 8'h12);
		ri(`RTC_IDX_MIN, 8'h45);
		$display("serial link done");
		droop(1'h1, 1'h0);
		ri(`RTC_IDX_CTRL2, 8'h40);
		wi(`RTC_IDX_CTRL2, 8'h80);
		droop(1'h1, 1'h0);
		ri(`RTC_IDX_CTRL2, 8'h80);
		droop(1'h1, 1'h1);
		ri(`RTC_IDX_CTRL2, 8'hC0);
		$display("supply monitor done");
		wi(`RTC_IDX_CTRL1, 8'h30);
		sub_chk(1'h1);
		wi(`RTC_IDX_CTRL2, 8'h08);
		sub_chk(1'h0);
		wi(`RTC_IDX_CTRL1, 8'h20);
		sub_chk(1'h1);
		subclock_gate_input <= 1'h0;
		sub_chk(1'h0);
		subclock_gate_input <= 1'h1;
		$display("subclock done");
		osc_run <= 1'h0;
		repeat (STOP_CYC + 500) @(posedge aclk);
		osc_run <= 1'h1;
		ri(`RTC_IDX_CTRL2, 8'h10);
		ri(`RTC_IDX_CTRL1, 8'h00);
		ri(`RTC_IDX_TRIM, 8'h00);
		$display("oscillator stop done");
		// 23:59:59 on 28 February 2000, alarms at 00:00 on day 0, hourly event interrupt.
		wi(`RTC_IDX_CTRL2, 8'h00);
		wi(`RTC_IDX_CTRL1, 8'hE6);
		for (int i = 0; i < 13; i++)
			wi(i[3:0], 8'(104'h00_00_01_00_00_00_00_82_28_06_23_59_59 >> (8 * i)));
		while (!interrupt_request_out_oe)
			@(posedge aclk);
		for (int i = 0; i < 7; i++)
			ri(i[3:0], 8'(56'h00_82_29_00_00_00_00 >> (8 * i)));
		ri(`RTC_IDX_CTRL2, 8'h07);
		wi(`RTC_IDX_CTRL1, 8'hE0);
		chk({31'h0, interrupt_request_out_oe}, 32'h1);
		$display("calendar tick done");
		summarize();
	end
endmodule : serial_rtc_alarm_timer_tb
